// File: logic/ccr_map.vh
// Constants for the channel cycle control and I/O recovery block
// Contract
// - Fast ROM select low: ROM reads run as plain default channel reads.
// - Fast ROM select high: extra wait states added to ROM reads.
// - Early-end during board DRAM access gives processor ready next cycle.
// - DMA status lines are inputs when DMA masters, outputs when processor does.
// - Next-address output drives the processor for address pipelining.
// - Recovery selects sampled at command strobe start, processor I/O cycles only.
// - Two sampled select bits pick one of four recovery durations.
// - I/O cycle end starts recovery timer; it expires after chosen duration.
// - Next I/O cycle waits before command strobe until timer expires.
// - Processor ready output completes all cycles, early-ended DRAM ones too.
`ifndef CCR_MAP_VH
`define CCR_MAP_VH
`define CCR_ADDR_W        4
`define CCR_OFS_CTRL      4'h0
`define CCR_OFS_STATUS    4'h4
`define CCR_CTRL_ROMWS_LO 0
`define CCR_CTRL_ROMWS_HI 3
`define CCR_CTRL_RECEN    8
`define CCR_CTRL_RST      32'h0000_0104
`define CCR_REC0_CYC      8
`define CCR_REC1_CYC      16
`define CCR_REC2_CYC      32
`define CCR_REC3_CYC      64
`define CCR_CMD_CYC       4'h2
`endif

// File: logic/ccr_recovery_timer.v
// I/O recovery timer with four selectable durations
`timescale 1ns/10ps
`include "ccr_map.vh"
module ccr_recovery_timer #(
  parameter integer REC0 = `CCR_REC0_CYC,
  parameter integer REC1 = `CCR_REC1_CYC,
  parameter integer REC2 = `CCR_REC2_CYC,
  parameter integer REC3 = `CCR_REC3_CYC
) (
  input  wire       clock,     // processor clock
  input  wire       reset_n,   // async reset, active low
  input  wire       sel_load,  // command strobe leading edge of a processor I/O cycle
  input  wire [1:0] sel_in,    // recovery select pair
  input  wire       start,     // I/O cycle finished
  output reg  [1:0] sel_q,     // latched select
  output reg        busy_q     // recovery running
);
  reg [7:0] cnt_q;
  reg [7:0] dur;

  always @* begin
    case (sel_q)
      2'b00:   dur = REC0[7:0];
      2'b01:   dur = REC1[7:0];
      2'b10:   dur = REC2[7:0];
      default: dur = REC3[7:0];
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sel_q  <= 2'b00;
      cnt_q  <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      if (sel_load) begin
        sel_q <= sel_in;
      end
      if (start) begin
        cnt_q  <= dur - 8'h01;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == 8'h00) begin
          busy_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end
endmodule

// File: logic/ccr_cycle_ctrl.v
// Processor cycle control: channel strobes, ROM wait states, DRAM early end, I/O recovery
`timescale 1ns/10ps
`include "ccr_map.vh"
module ccr_cycle_ctrl #(
  parameter integer REC0 = `CCR_REC0_CYC,
  parameter integer REC1 = `CCR_REC1_CYC,
  parameter integer REC2 = `CCR_REC2_CYC,
  parameter integer REC3 = `CCR_REC3_CYC
) (
  input  wire        clock,                        // processor clock, 250 MHz
  input  wire        reset_n,                      // async reset, active low
  input  wire        cpu_addr_strobe_n,            // processor address valid
  input  wire        cpu_write_or_read,            // 1 write, 0 read
  input  wire        cpu_data_or_ctrl,             // 1 data, 0 control
  input  wire        channel_mem_or_io,            // 1 memory, 0 I/O
  input  wire        board_dram_hit_n,             // board DRAM decode
  input  wire        dram_early_end_n,             // terminate DRAM access
  input  wire        rom_hit_n,                    // ROM decode
  input  wire        cpu_ready_in_n,               // processor ready seen on bus
  input  wire        channel_ready_n,              // channel not ready when high
  input  wire        fast_rom_select_n,            // strap, async
  input  wire        recovery_sel_hi,              // recovery select bit 1
  input  wire        recovery_sel_lo,              // recovery select bit 0
  input  wire        dma_master,                   // DMA owns the bus
  input  wire        dma_stat0_n_in,               // DMA status 0 pin level
  input  wire        dma_stat1_n_in,               // DMA status 1 pin level
  output reg         dma_stat0_n_out,              // DMA status 0 drive value
  output reg         dma_stat1_n_out,              // DMA status 1 drive value
  output reg         dma_stat_oe_n,                // low while driving status pins
  output reg         cpu_ready_out_n,              // processor ready
  output reg         next_addr_req_n,              // next address request
  output reg         channel_addr_latch_n,         // channel address latch
  output reg         channel_cmd_strobe_n,         // channel command
  output reg         channel_matched_mem_strobe_n, // matched memory command
  output reg         channel_stat0_n,              // channel status 0
  output reg         channel_stat1_n,              // channel status 1
  input  wire        psel,                         // APB select
  input  wire        penable,                      // APB enable
  input  wire        pwrite,                       // APB write
  input  wire [31:0] paddr,                        // APB byte address
  input  wire [31:0] pwdata,                       // APB write data
  output reg  [31:0] prdata,                       // APB read data
  output reg         pready,                       // APB ready
  output reg         pslverr                       // APB error
);
  localparam [2:0] ST_IDLE = 3'b000;
  localparam [2:0] ST_DRAM = 3'b001;
  localparam [2:0] ST_ADDR = 3'b010;
  localparam [2:0] ST_HOLD = 3'b011;
  localparam [2:0] ST_CMD  = 3'b100;
  localparam [2:0] ST_END  = 3'b101;

  reg  [2:0]  state_q;
  reg  [4:0]  wait_q;
  reg         is_io_q;
  reg         is_rom_q;
  reg         is_mem_q;
  reg  [31:0] ctrl_q;
  reg  [1:0]  frs_sync_q;
  reg  [1:0]  ds0_sync_q;
  reg  [1:0]  ds1_sync_q;
  reg         sel_load;
  reg         rec_start;
  wire        rec_busy;
  wire [1:0]  rec_sel;
  wire        rom_slow;
  wire        rec_en;
  wire [4:0]  cmd_len;
  wire [3:0]  rom_ws;

  // Straps and DMA-driven status come from outside this clock
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frs_sync_q <= 2'b00;
      ds0_sync_q <= 2'b11;
      ds1_sync_q <= 2'b11;
    end else begin
      frs_sync_q <= {frs_sync_q[0], fast_rom_select_n};
      ds0_sync_q <= {ds0_sync_q[0], dma_stat0_n_in};
      ds1_sync_q <= {ds1_sync_q[0], dma_stat1_n_in};
    end
  end

  assign rom_slow = frs_sync_q[1];
  assign rec_en   = ctrl_q[`CCR_CTRL_RECEN];
  assign rom_ws   = ctrl_q[`CCR_CTRL_ROMWS_HI:`CCR_CTRL_ROMWS_LO];
  // Slow ROM stretches the command; one extra bit so 2 plus a wait count of 15, a total of 17, cannot wrap
  assign cmd_len  = (is_rom_q && rom_slow) ?
                    ({1'b0, `CCR_CMD_CYC} + {1'b0, rom_ws}) :
                    {1'b0, `CCR_CMD_CYC};

  ccr_recovery_timer #(
    .REC0(REC0),
    .REC1(REC1),
    .REC2(REC2),
    .REC3(REC3)
  ) u_rec (
    .clock    (clock),
    .reset_n  (reset_n),
    .sel_load (sel_load),
    .sel_in   ({recovery_sel_hi, recovery_sel_lo}),
    .start    (rec_start),
    .sel_q    (rec_sel),
    .busy_q   (rec_busy)
  );

  always @* begin
    sel_load  = 1'b0;
    rec_start = 1'b0;
    // Selects only meaningful for processor I/O; DMA cycles never reach here
    if ((state_q == ST_ADDR || state_q == ST_HOLD) && is_io_q &&
        !(rec_busy && rec_en)) begin
      sel_load = 1'b1;
    end
    if (state_q == ST_END && is_io_q && rec_en) begin
      rec_start = 1'b1;
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q                      <= ST_IDLE;
      wait_q                       <= 5'h00;
      is_io_q                      <= 1'b0;
      is_rom_q                     <= 1'b0;
      is_mem_q                     <= 1'b0;
      cpu_ready_out_n              <= 1'b1;
      next_addr_req_n              <= 1'b1;
      channel_addr_latch_n         <= 1'b1;
      channel_cmd_strobe_n         <= 1'b1;
      channel_matched_mem_strobe_n <= 1'b1;
      channel_stat0_n              <= 1'b1;
      channel_stat1_n              <= 1'b1;
    end else begin
      cpu_ready_out_n <= 1'b1;
      next_addr_req_n <= 1'b1;
      case (state_q)
        ST_IDLE: begin
          if (!cpu_addr_strobe_n && !dma_master) begin
            is_io_q  <= !channel_mem_or_io && cpu_data_or_ctrl;
            is_mem_q <= channel_mem_or_io;
            is_rom_q <= !rom_hit_n && !cpu_write_or_read;
            if (!board_dram_hit_n) begin
              state_q <= ST_DRAM;
            end else begin
              state_q              <= ST_ADDR;
              channel_addr_latch_n <= 1'b0;
              channel_stat0_n      <= cpu_write_or_read;
              channel_stat1_n      <= !cpu_write_or_read;
            end
          end
        end
        ST_DRAM: begin
          if (!dram_early_end_n) begin
            cpu_ready_out_n <= 1'b0;
            next_addr_req_n <= 1'b0;
            state_q         <= ST_END;
          end
        end
        ST_ADDR, ST_HOLD: begin
          channel_addr_latch_n <= 1'b1;
          if (is_io_q && rec_busy && rec_en) begin
            state_q <= ST_HOLD;
          end else begin
            state_q                      <= ST_CMD;
            wait_q                       <= cmd_len;
            channel_cmd_strobe_n         <= 1'b0;
            channel_matched_mem_strobe_n <= !is_mem_q;
          end
        end
        ST_CMD: begin
          if (wait_q != 5'h00) begin
            wait_q <= wait_q - 5'h01;
          end else if (!channel_ready_n) begin
            channel_cmd_strobe_n         <= 1'b1;
            channel_matched_mem_strobe_n <= 1'b1;
            channel_stat0_n              <= 1'b1;
            channel_stat1_n              <= 1'b1;
            cpu_ready_out_n              <= 1'b0;
            next_addr_req_n              <= 1'b0;
            state_q                      <= ST_END;
          end
        end
        ST_END: begin
          // One idle cycle lets the address strobe of this cycle drop
          is_io_q  <= 1'b0;
          state_q  <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // DMA status pins: driven from processor status only while it masters
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dma_stat_oe_n   <= 1'b1;
      dma_stat0_n_out <= 1'b1;
      dma_stat1_n_out <= 1'b1;
    end else begin
      dma_stat_oe_n   <= dma_master;
      dma_stat0_n_out <= channel_stat0_n;
      dma_stat1_n_out <= channel_stat1_n;
    end
  end

  // APB slave; answer one cycle into the access phase
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q  <= `CCR_CTRL_RST;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      // Write lands only on the edge where the master sees pready
      if (psel && penable && pready && pwrite && !pslverr &&
          paddr[`CCR_ADDR_W-1:0] == `CCR_OFS_CTRL) begin
        ctrl_q <= pwdata & (`CCR_CTRL_RST | 32'h0000_000F);
      end
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= 32'h0000_0000;
        case (paddr[`CCR_ADDR_W-1:0])
          `CCR_OFS_CTRL: begin
            if (!pwrite) begin
              prdata <= ctrl_q;
            end
          end
          `CCR_OFS_STATUS: begin
            if (!pwrite) begin
              prdata <= {22'h000000, ds1_sync_q[1], ds0_sync_q[1], cpu_ready_in_n,
                         rom_slow, rec_sel, rec_busy, state_q};
            end
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
        if (paddr[31:`CCR_ADDR_W] != 28'h0000000) begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule

// File: dv/ccr_cycle_chk.sv
// Port checks for the cycle control block
`timescale 1ns/10ps
module ccr_cycle_chk (
  input wire clock,             // clock
  input wire reset_n,           // reset
  input wire cpu_addr_strobe_n, // cycle start
  input wire cpu_data_or_ctrl,  // data or control
  input wire cpu_write_or_read, // write or read
  input wire channel_mem_or_io, // memory or I/O
  input wire board_dram_hit_n,  // DRAM decode
  input wire dram_early_end_n,  // DRAM early end
  input wire rom_hit_n,         // ROM decode
  input wire fast_rom_select_n, // ROM speed
  input wire channel_ready_n,   // channel ready
  input wire dma_master,        // DMA owns bus
  input wire dma_stat_oe_n,     // status drive
  input wire cpu_ready_out_n,   // ready
  input wire next_addr_req_n,   // next address
  input wire channel_cmd_strobe_n // command
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_EARLY_END: assert property (
    $fell(dram_early_end_n) && !board_dram_hit_n |=> !cpu_ready_out_n)
    else $error("early end gave no ready");
  AST_DRAM_LOCAL: assert property (
    !cpu_addr_strobe_n && !board_dram_hit_n && channel_mem_or_io |=> channel_cmd_strobe_n [*3])
    else $error("board DRAM access ran a channel command");
  AST_RDY_PULSE: assert property (!cpu_ready_out_n |=> cpu_ready_out_n)
    else $error("ready held longer than one cycle");
  AST_NEXT_ADDR: assert property (next_addr_req_n == cpu_ready_out_n)
    else $error("next address not paired with ready");
  AST_DMA_OE: assert property (1'b1 |=> dma_stat_oe_n == $past(dma_master))
    else $error("status drive does not follow bus master");
  AST_IO_HOLD: assert property (
    !cpu_ready_out_n && !channel_mem_or_io && cpu_data_or_ctrl |=> channel_cmd_strobe_n [*5])
    else $error("I/O command inside recovery time");
  AST_SLOW_ROM: assert property (
    $fell(channel_cmd_strobe_n) && !rom_hit_n && !cpu_write_or_read && fast_rom_select_n
    |-> !channel_cmd_strobe_n [*5]) else $error("slow ROM command too short");
  AST_FAST_ROM: assert property (
    $fell(channel_cmd_strobe_n) && !rom_hit_n && !cpu_write_or_read && !fast_rom_select_n
    && !channel_ready_n |-> ##[3:4] $rose(channel_cmd_strobe_n))
    else $error("fast ROM not default");
  AST_RDY_BOUND: assert property (
    $fell(channel_cmd_strobe_n) |-> ##[1:40] !cpu_ready_out_n)
    else $error("channel cycle never completed");
  cover property ($fell(dram_early_end_n) && !board_dram_hit_n);
  cover property (!cpu_ready_out_n && !channel_mem_or_io && cpu_data_or_ctrl);
  cover property ($fell(channel_cmd_strobe_n) && !rom_hit_n && fast_rom_select_n);
  cover property (dma_master);
endmodule

// File: dv/ccr_chan_model.sv
// Channel slave with settable ready delay and status pin resolution
`timescale 1ns/10ps
module ccr_chan_model (
  input  wire       clock,   // processor clock
  input  wire       cmd_n,   // channel command
  input  wire [3:0] delay,   // cycles before ready
  input  wire       dma_drv, // DMA drives status
  input  wire [1:0] dma_val, // DMA status value
  input  wire [1:0] bc_val,  // block status value
  input  wire       bc_oe_n, // block drive enable
  output wire       ready_n, // channel ready return
  output wire [1:0] pin      // resolved status pins
);
  logic [3:0] cnt = 4'h0;
  always @(posedge clock) begin
    cnt <= cmd_n ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
  end
  // Pulled up outside a command, so a stale low never reads as ready
  assign ready_n = cmd_n | (cnt < delay);
  // Pull-ups hold the lines high when nobody drives
  assign pin = !bc_oe_n ? bc_val : (dma_drv ? dma_val : 2'b11);
endmodule

// File: dv/test_channel_cycle_control_io_recovery.sv
// Directed bench for the cycle control block
`timescale 1ns/10ps
`include "ccr_map.vh"
module test_channel_cycle_control_io_recovery;
  localparam int REC [4] = '{6, 9, 12, 15};
  logic        clock, reset_n, cpu_addr_strobe_n, cpu_write_or_read, cpu_data_or_ctrl;
  logic        channel_mem_or_io, board_dram_hit_n, dram_early_end_n, rom_hit_n, dma_master;
  logic        fast_rom_select_n, recovery_sel_hi, recovery_sel_lo, psel, penable, pwrite, er;
  logic [31:0] paddr, pwdata, rd;
  logic [3:0]  dly;
  logic [1:0]  st;
  logic        mm;
  wire         channel_ready_n, dma_stat0_n_out, dma_stat1_n_out, dma_stat_oe_n, pready;
  wire         cpu_ready_out_n, next_addr_req_n, channel_addr_latch_n, channel_cmd_strobe_n;
  wire         channel_matched_mem_strobe_n, channel_stat0_n, channel_stat1_n, pslverr;
  wire  [31:0] prdata;
  wire  [1:0]  pin;
  int          errors = 0, check_count = 0, cyc = 0, rdy_at = 0, g, clen, fast_len;
  int          gap [4];
  ccr_cycle_ctrl #(.REC0(6), .REC1(9), .REC2(12), .REC3(15)) ccr_cycle_ctrl_i (
    .clock, .reset_n, .cpu_addr_strobe_n, .cpu_write_or_read, .cpu_data_or_ctrl,
    .channel_mem_or_io, .board_dram_hit_n, .dram_early_end_n, .rom_hit_n,
    .cpu_ready_in_n(cpu_ready_out_n), .channel_ready_n, .fast_rom_select_n,
    .recovery_sel_hi, .recovery_sel_lo, .dma_master, .dma_stat0_n_in(pin[0]),
    .dma_stat1_n_in(pin[1]), .dma_stat0_n_out, .dma_stat1_n_out, .dma_stat_oe_n,
    .cpu_ready_out_n, .next_addr_req_n, .channel_addr_latch_n, .channel_cmd_strobe_n,
    .channel_matched_mem_strobe_n, .channel_stat0_n, .channel_stat1_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  ccr_chan_model ccr_chan_model_i (.clock, .cmd_n(channel_cmd_strobe_n), .delay(dly),
    .dma_drv(dma_master), .dma_val(2'b01), .bc_val({dma_stat1_n_out, dma_stat0_n_out}),
    .bc_oe_n(dma_stat_oe_n), .ready_n(channel_ready_n), .pin);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] v);
    check_count++;
    if (v !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, v);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Strobe stays low until the address latch shows the cycle was taken
  task run_cyc(input logic m, input logic rom, input logic [1:0] s);
    @(posedge clock);
    {cpu_addr_strobe_n, channel_mem_or_io, rom_hit_n} <= {1'b0, m, !rom};
    {recovery_sel_hi, recovery_sel_lo} <= s;
    do @(negedge clock); while (channel_addr_latch_n !== 1'b0);
    @(posedge clock);
    cpu_addr_strobe_n <= 1'b1;
    do @(negedge clock); while (channel_cmd_strobe_n !== 1'b0);
    mm = channel_matched_mem_strobe_n;
    st = {channel_stat1_n, channel_stat0_n};
    g = cyc - rdy_at;
    clen = cyc;
    do @(negedge clock); while (cpu_ready_out_n !== 1'b0);
    clen = cyc - clen;
    rdy_at = cyc;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {reset_n, cpu_addr_strobe_n, cpu_write_or_read, cpu_data_or_ctrl, channel_mem_or_io} = 5'h0B;
    {board_dram_hit_n, dram_early_end_n, rom_hit_n, dma_master, fast_rom_select_n} = 5'h1C;
    {recovery_sel_hi, recovery_sel_lo, psel, penable, pwrite} = 5'h00;
    {paddr, pwdata, dly} = '0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    apb(1'b0, `CCR_OFS_CTRL, 32'h0);
    chk("ctrl reset", `CCR_CTRL_RST, rd);
    apb(1'b0, 32'h0000_0008, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    $display("register test done");
    run_cyc(1'b1, 1'b1, 2'h0);
    fast_len = clen;
    chk("rom matched strobe", 32'h0, {31'h0, mm});
    chk("rom read status", 32'h2, {30'h0, st});
    @(posedge clock) fast_rom_select_n <= 1'b1;
    repeat (4) @(posedge clock);
    run_cyc(1'b1, 1'b1, 2'h0);
    chk("slow rom extra", 32'h4, 32'(clen - fast_len));
    apb(1'b1, `CCR_OFS_CTRL, 32'h0000_0102);
    run_cyc(1'b1, 1'b1, 2'h0);
    chk("slow rom extra 2", 32'h2, 32'(clen - fast_len));
    // ROM writes never take the slow-ROM stretch
    @(posedge clock) cpu_write_or_read <= 1'b1;
    run_cyc(1'b1, 1'b1, 2'h0);
    chk("rom write len", 32'(fast_len), 32'(clen));
    chk("rom write status", 32'h1, {30'h0, st});
    @(posedge clock) {cpu_write_or_read, fast_rom_select_n} <= 2'b00;
    $display("rom test done");
    // Second cycle carries the other select, so only the latched one may count
    @(posedge clock) dly <= 4'h6;
    for (int s = 0; s < 4; s++) begin
      run_cyc(1'b0, 1'b0, 2'(s));
      run_cyc(1'b0, 1'b0, ~2'(s));
      gap[s] = g;
      check_count++;
      // Busy for REC cycles after the ready cycle, command on the edge after
      if (gap[s] != REC[s] + 2 || (s > 0 && gap[s] <= gap[s-1])) begin
        errors++;
        $display("[ERR] recovery gap %0d expected %0d seen %0d", s, REC[s] + 2, gap[s]);
      end
      chk("io matched strobe", 32'h1, {31'h0, mm});
    end
    $display("recovery test done");
    repeat (3) @(posedge clock);
    {cpu_addr_strobe_n, channel_mem_or_io, board_dram_hit_n} <= 3'b010;
    @(posedge clock);
    cpu_addr_strobe_n <= 1'b1;
    @(posedge clock);
    dram_early_end_n <= 1'b0;
    @(posedge clock);
    dram_early_end_n <= 1'b1;
    @(negedge clock);
    chk("dram ready", 32'h0, {31'h0, cpu_ready_out_n});
    chk("dram next addr", 32'h0, {31'h0, next_addr_req_n});
    @(posedge clock) board_dram_hit_n <= 1'b1;
    $display("dram test done");
    @(posedge clock) dma_master <= 1'b1;
    repeat (3) @(negedge clock);
    chk("dma oe off", 32'h1, {31'h0, dma_stat_oe_n});
    chk("dma pins", 32'h1, {30'h0, pin});
    apb(1'b0, `CCR_OFS_STATUS, 32'h0);
    chk("status dma pins", 32'h0000_0180, rd);
    @(posedge clock) dma_master <= 1'b0;
    repeat (3) @(negedge clock);
    chk("dma oe on", 32'h0, {31'h0, dma_stat_oe_n});
    $display("dma test done");
    wrap_up();
  end
endmodule
bind ccr_cycle_ctrl ccr_cycle_chk ccr_cycle_chk_i (.clock, .reset_n, .cpu_addr_strobe_n,
  .cpu_data_or_ctrl, .cpu_write_or_read, .channel_mem_or_io, .board_dram_hit_n,
  .dram_early_end_n, .rom_hit_n,
  .fast_rom_select_n, .channel_ready_n, .dma_master, .dma_stat_oe_n, .cpu_ready_out_n,
  .next_addr_req_n, .channel_cmd_strobe_n);
